// ==== pkg/ahp_params.svh ====
`ifndef AHP_PARAMS_SVH
`define AHP_PARAMS_SVH
// apb register byte offsets
`define AHP_OFF_CTRL0 8'h00
`define AHP_OFF_CTRL1 8'h04
`define AHP_OFF_CHAN 8'h08
`define AHP_OFF_STATUS 8'h0C
// control registers loaded from the host pins
`define AHP_CTRL_W 10
`define AHP_CTRL0_RST 10'h000
`define AHP_CTRL1_RST 10'h030
`define AHP_FRST_BIT 1
`define AHP_THR_LSB 2
`define AHP_THR_MSB 3
`define AHP_FORM_BIT 4
`define AHP_POL_BIT 5
`define AHP_RW_BIT 6
// channel count register, code is active channels minus one
`define AHP_CHAN_RST 2'h0
// status register fields
`define AHP_STAT_FILL_LSB 0
`define AHP_STAT_FLAG_BIT 6
`define AHP_STAT_OVF_BIT 8
// synchronised pin vector positions
`define AHP_PIN_SELN 0
`define AHP_PIN_SELH 1
`define AHP_PIN_RDN 2
`define AHP_PIN_WRN 3
`define AHP_PIN_RSEL 4
`define AHP_PIN_SCLK 5
`define AHP_PIN_DATA 6
`define AHP_PIN_RST 6'h0D
// threshold tables, 5 bits per code, code 0 in the low bits
`define AHP_THR_W 5
`define AHP_THR_CH1 20'h72081
`define AHP_THR_CH2 20'h62082
`define AHP_THR_CH3 20'h624C3
`define AHP_THR_CH4 20'h63104
`endif

// ==== pkg/ahp_pkg.sv ====
package ahp_pkg;
  // flag sequencer states
  typedef enum logic [3:0] {
    AHP_ARMED = 4'h1,
    AHP_LEVEL = 4'h2,
    AHP_PULSE = 4'h4,
    AHP_DRAIN = 4'h8
  } ahp_flag_state_type;
endpackage : ahp_pkg

// ==== pkg/ahp_sync_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// raw pin levels in, filtered levels out
interface ahp_sync_if #(parameter int W = 16);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src(output raw, input clean);
  modport snk(input raw, output clean);
endinterface : ahp_sync_if
`default_nettype wire

// ==== hw/ahp_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module ahp_sync #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  ahp_sync_if.snk port
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] clean_reg;

  ////////////////////////////////////////////////////////////////
  // three stage chain, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
    end else if (clk_en) begin
      s1_reg <= port.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // a bit changes only once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        clean_reg[i] <= RST[i];
      end else if (clk_en && (s2_reg[i] == s3_reg[i])) begin
        clean_reg[i] <= s3_reg[i];
      end
    end
  end

  assign port.clean = clean_reg;
endmodule : ahp_sync
`default_nettype wire

// ==== hw/ahp_host_port.sv ====
// Function
// - threshold code comes from control register 1 bits 3 (msb) and 2.
// - one channel codes give 1,4,8,14; two channels give 2,4,8,12.
// - three channels give 3,6,9,12; four give 4,8,12, code 11 reserved.
// - each differential pair or single input counts as one channel.
// - flag goes active in its chosen form when fill reaches threshold.
// - results leave the fifo in the order they were stored.
// - read strobe is both selects and read, with write inactive.
// - each read strobe pops one word and enables the data drivers.
// - write strobe is both selects and write, with read inactive.
// - write strobe loads the bus word into control register 0 or 1.
// - write pin may serve as a combined direction input.
// - control register 1 bit 4 picks level (0) or pulse (1).
// - control register 1 bit 5 picks active low (0) or high (1).
// - level flag drops when the first of the threshold reads starts.
// - level condition is checked again after threshold reads complete.
// - pulse lasts half a sampling clock period.
// - no new pulse until threshold results before the last are read.
// - control register 1 bit 6 set selects combined direction mode.
// - in combined mode direction high means read, low means write.
//
// Local design decisions: the address map and the APB slave port.
`include "ahp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ahp_host_port #(
  parameter int DW = 10,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic select_low_n,
  input wire logic select_high,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_sel,
  input wire logic sampling_clock_in,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  output logic results_ready_flag,
  input wire logic result_valid,
  input wire logic [DW-1:0] result_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = `AHP_PIN_DATA + DW;
  localparam int TW = `AHP_THR_W;

  ////////////////////////////////////////////////////////////////
  // threshold lookup by channel code and selection code
  function automatic logic [TW-1:0] thr_decode(input logic [1:0] chan,
                                               input logic [1:0] code);
    logic [4*TW-1:0] tbl;
    tbl = '0;
    unique case (chan)
      2'h0: tbl = `AHP_THR_CH1;
      2'h1: tbl = `AHP_THR_CH2;
      2'h2: tbl = `AHP_THR_CH3;
      2'h3: tbl = `AHP_THR_CH4;
    endcase
    return tbl[code*TW +: TW];
  endfunction : thr_decode

  ////////////////////////////////////////////////////////////////
  // pin synchroniser
  ahp_sync_if #(.W(PW)) pin_if();
  assign pin_if.raw = {data_in, sampling_clock_in, reg_sel, wr_n, rd_n,
                       select_high, select_low_n};

  ahp_sync #(
    .W(PW),
    .RST({{DW{1'b0}}, `AHP_PIN_RST})
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .port(pin_if.snk)
  );

  wire logic seln = pin_if.clean[`AHP_PIN_SELN];
  wire logic selh = pin_if.clean[`AHP_PIN_SELH];
  wire logic rdn = pin_if.clean[`AHP_PIN_RDN];
  wire logic wrn = pin_if.clean[`AHP_PIN_WRN];
  wire logic rsel = pin_if.clean[`AHP_PIN_RSEL];
  wire logic sclk = pin_if.clean[`AHP_PIN_SCLK];
  wire logic [DW-1:0] pin_data = pin_if.clean[`AHP_PIN_DATA +: DW];

  ////////////////////////////////////////////////////////////////
  // state
  logic [`AHP_CTRL_W-1:0] ctrl0_reg;
  logic [`AHP_CTRL_W-1:0] ctrl1_reg;
  logic [1:0] chan_reg;
  logic rd_int_reg;
  logic wr_int_reg;
  logic wr_sel_reg;
  logic [DW-1:0] wr_data_reg;
  logic sclk_reg;
  logic [DW-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic ovf_reg;
  logic [DW-1:0] dout_reg;
  logic [TW-1:0] left_reg;
  logic [TW-1:0] left_next;
  logic flag_reg;
  logic [31:0] prdata_reg;
  ahp_pkg::ahp_flag_state_type state_reg;
  ahp_pkg::ahp_flag_state_type state_next;

  ////////////////////////////////////////////////////////////////
  // internal strobes from selects, read and write pins
  wire logic rw_mode = ctrl1_reg[`AHP_RW_BIT];
  wire logic sel_ok = ~seln & selh;
  // combined mode: write pin high reads, low writes, read pin ignored
  wire logic rd_int = sel_ok & wrn & (rw_mode | ~rdn);
  wire logic wr_int = sel_ok & ~wrn & (rw_mode | rdn);
  wire logic rd_start = rd_int & ~rd_int_reg;
  wire logic wr_end = ~wr_int & wr_int_reg;

  ////////////////////////////////////////////////////////////////
  // fifo status and threshold decode
  wire logic [AW:0] fill = wptr_reg - rptr_reg;
  wire logic full = fill == (AW+1)'(DEPTH);
  wire logic empty = fill == '0;
  wire logic push = result_valid & ~full;
  wire logic pop = rd_start & ~empty;
  wire logic [1:0] thr_code = {ctrl1_reg[`AHP_THR_MSB],
                               ctrl1_reg[`AHP_THR_LSB]};
  // chan_reg holds one channel count code, each pair or single input one channel
  wire logic [TW-1:0] thr = thr_decode(chan_reg, thr_code);
  wire logic thr_met = (TW+1)'(fill) >= (TW+1)'(thr);
  wire logic pulse_form = ctrl1_reg[`AHP_FORM_BIT];
  wire logic pol = ctrl1_reg[`AHP_POL_BIT];
  wire logic sclk_rise = sclk & ~sclk_reg;
  wire logic sclk_fall = ~sclk & sclk_reg;
  wire logic frst = wr_end & wr_sel_reg & wr_data_reg[`AHP_FRST_BIT];

  ////////////////////////////////////////////////////////////////
  // strobe edges and write capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_int_reg <= 1'b0;
      wr_int_reg <= 1'b0;
      wr_sel_reg <= 1'b0;
      wr_data_reg <= '0;
      sclk_reg <= 1'b0;
    end else if (clk_en) begin
      rd_int_reg <= rd_int;
      wr_int_reg <= wr_int;
      sclk_reg <= sclk;
      if (wr_int) begin
        wr_sel_reg <= rsel;
        wr_data_reg <= pin_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // control registers commit at the end of the write strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `AHP_CTRL0_RST;
      ctrl1_reg <= `AHP_CTRL1_RST;
    end else if (clk_en && wr_end) begin
      if (wr_sel_reg) begin
        ctrl1_reg <= wr_data_reg[`AHP_CTRL_W-1:0];
      end else begin
        ctrl0_reg <= wr_data_reg[`AHP_CTRL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // result fifo, strict first in first out
  always_ff @(posedge pclk) begin
    if (clk_en && push) begin
      mem[wptr_reg[AW-1:0]] <= result_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      dout_reg <= '0;
    end else if (clk_en) begin
      if (frst) begin
        wptr_reg <= '0;
        rptr_reg <= '0;
      end else begin
        if (push) begin
          wptr_reg <= wptr_reg + 1'b1;
        end
        if (pop) begin
          rptr_reg <= rptr_reg + 1'b1;
        end
      end
      if (pop) begin
        dout_reg <= mem[rptr_reg[AW-1:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // reads still owed since the last assertion
  always_comb begin
    left_next = left_reg;
    if (rd_start && left_reg != '0) begin
      left_next = left_reg - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // flag sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ahp_pkg::AHP_ARMED: begin
        if (thr_met && !pulse_form) begin
          state_next = ahp_pkg::AHP_LEVEL;
        end else if (thr_met && sclk_rise) begin
          state_next = ahp_pkg::AHP_PULSE;
        end
      end
      ahp_pkg::AHP_LEVEL: begin
        if (rd_start) begin
          // first read drops the flag
          state_next = ahp_pkg::AHP_DRAIN;
        end
      end
      ahp_pkg::AHP_PULSE: begin
        if (sclk_fall) begin
          state_next = ahp_pkg::AHP_DRAIN;
        end
      end
      ahp_pkg::AHP_DRAIN: begin
        if (left_next == '0) begin
          state_next = ahp_pkg::AHP_ARMED;
        end
      end
      default: begin
        state_next = ahp_pkg::AHP_ARMED;
      end
    endcase
  end

  wire logic flag_on_next = (state_next == ahp_pkg::AHP_LEVEL) ||
                            (state_next == ahp_pkg::AHP_PULSE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ahp_pkg::AHP_ARMED;
      left_reg <= '0;
      flag_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (state_reg == ahp_pkg::AHP_ARMED && state_next != ahp_pkg::AHP_ARMED) begin
        left_reg <= thr;
      end else begin
        left_reg <= left_next;
      end
      flag_reg <= flag_on_next ? pol : ~pol;
    end
  end

  ////////////////////////////////////////////////////////////////
  // overflow sticky bit, a new overflow beats the clear
  wire logic stat_hit = paddr == `AHP_OFF_STATUS;
  wire logic apb_wr = psel & penable & pwrite;
  wire logic ovf_clr = apb_wr & stat_hit & pwdata[`AHP_STAT_OVF_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
    end else if (clk_en) begin
      if (result_valid && full) begin
        ovf_reg <= 1'b1;
      end else if (ovf_clr) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb decode and read mux
  wire logic hit_c0 = paddr == `AHP_OFF_CTRL0;
  wire logic hit_c1 = paddr == `AHP_OFF_CTRL1;
  wire logic hit_ch = paddr == `AHP_OFF_CHAN;
  wire logic hit = hit_c0 | hit_c1 | hit_ch | stat_hit;
  wire logic [31:0] stat_word = 32'(ovf_reg) << `AHP_STAT_OVF_BIT |
                                32'(flag_on_next) << `AHP_STAT_FLAG_BIT |
                                32'(fill) << `AHP_STAT_FILL_LSB;
  wire logic [31:0] rd_mux = hit_c0 ? 32'(ctrl0_reg) :
                             hit_c1 ? 32'(ctrl1_reg) :
                             hit_ch ? 32'(chan_reg) :
                             stat_hit ? stat_word : 32'h0000_0000;

  // read data is caught in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      chan_reg <= `AHP_CHAN_RST;
    end else if (clk_en) begin
      if (psel && !penable && !pwrite) begin
        prdata_reg <= rd_mux;
      end
      if (apb_wr && hit_ch) begin
        chan_reg <= pwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign data_out = dout_reg;
  assign data_oe = rd_int_reg;
  assign results_ready_flag = flag_reg;
endmodule : ahp_host_port
`default_nettype wire

// ==== tb/ahp_host_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the host port
module ahp_host_monitor #(
  parameter int DW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic select_low_n,
  input wire logic select_high,
  input wire logic wr_n,
  input wire logic [DW-1:0] data_out,
  input wire logic data_oe,
  input wire logic results_ready_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // apb answers
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_bad; psel && penable && paddr > 8'h0C |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("no error on unmapped address");
  property p_ok;
    psel && penable && paddr[1:0] == 2'h0 && paddr <= 8'h0C |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("error on mapped address");
  property p_eph; pslverr |-> psel && penable; endproperty
  a_eph: assert property (p_eph) else $error("error outside access phase");
  property p_prd; psel && penable |=> $stable(prdata); endproperty
  a_prd: assert property (p_prd) else $error("read data moved after access");
  // pin read strobe
  property p_oe_on; $rose(data_oe) |-> $past(!select_low_n && select_high && wr_n, 2); endproperty
  a_oe_on: assert property (p_oe_on) else $error("drivers on without read");
  property p_oe_off; !select_high [*8] |-> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("drivers on after deselect");
  property p_dout; $changed(data_out) |-> data_oe; endproperty
  a_dout: assert property (p_dout) else $error("data moved without read");
  // main scenarios
  c_rd: cover property ($rose(data_oe));
  c_flag: cover property ($fell(results_ready_flag));
  c_err: cover property (pslverr);
endmodule : ahp_host_monitor
`default_nettype wire

// ==== tb/ahp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// processor bus side of the pin port
module ahp_host_model (
  input wire logic pclk,
  output logic select_low_n,
  output logic select_high,
  output logic rd_n,
  output logic wr_n,
  output logic reg_sel,
  output logic [9:0] data_in
);
  logic comb = 1'b0;
  // idle bus at time zero
  initial begin
    select_low_n = 1'b1;
    select_high = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    reg_sel = 1'b0;
    data_in = 10'h000;
  end
  // hold the strobe past the pin filter, then deselect and let it settle
  task automatic hold_rel();
    repeat (4) @(posedge pclk);
    select_low_n <= 1'b1;
    select_high <= 1'b0;
    rd_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : hold_rel
  task automatic host_rd();
    @(posedge pclk);
    wr_n <= 1'b1;
    rd_n <= comb;
    select_low_n <= 1'b0;
    select_high <= 1'b1;
    hold_rel();
  endtask : host_rd
  task automatic host_wr(input logic sel, input logic [9:0] d);
    @(posedge pclk);
    wr_n <= 1'b0;
    rd_n <= 1'b1;
    reg_sel <= sel;
    data_in <= d;
    select_low_n <= 1'b0;
    select_high <= 1'b1;
    hold_rel();
    wr_n <= 1'b1;
    data_in <= ~d; // released bus does not keep the last word
  endtask : host_wr
endmodule : ahp_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, data_oe, flag, sel_n, sel_h, rd_n, wr_n, reg_sel;
  logic sclk = 1'b0, sclk_run = 1'b0, res_valid = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [9:0] data_in, data_out, res_data = 10'h000;
  int n_mismatch = 0, compares = 0;
  int thr_t [4][4] = '{'{1, 4, 8, 14}, '{2, 4, 8, 12}, '{3, 6, 9, 12}, '{4, 8, 12, 0}};
  ////////////////////////////////////////////////////////////
  // clocks: sampling clock half period is four bus clocks
  always #12.5 pclk = ~pclk;
  always begin
    repeat (4) @(posedge pclk);
    if (sclk_run) sclk <= ~sclk;
  end
  ahp_host_port ahp_host_port_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .select_low_n(sel_n),
    .select_high(sel_h), .rd_n(rd_n), .wr_n(wr_n), .reg_sel(reg_sel),
    .sampling_clock_in(sclk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .results_ready_flag(flag), .result_valid(res_valid), .result_data(res_data));
  ahp_host_model ahp_host_model_inst (.pclk(pclk), .select_low_n(sel_n),
    .select_high(sel_h), .rd_n(rd_n), .wr_n(wr_n), .reg_sel(reg_sel), .data_in(data_in));
  ////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic reg_io(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] e, input logic ee, input string m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!wr) chk(prdata, e, m);
    chk(32'(pslverr), 32'(ee), m);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : reg_io
  task automatic push(input logic [9:0] v);
    @(posedge pclk);
    res_valid <= 1'b1;
    res_data <= v;
    @(posedge pclk);
    res_valid <= 1'b0;
  endtask : push
  task automatic wflag(input logic v, input int n, input string m);
    for (int i = 0; i < n && flag !== v; i++) @(posedge pclk);
    chk(32'(flag), 32'(v), m);
  endtask : wflag
  task automatic cfg(input logic [1:0] ch, input logic [9:0] w);
    reg_io(1'b1, 8'h08, 32'(ch), 32'h0, 1'b0, "chan");
    ahp_host_model_inst.host_wr(1'b1, w);
    reg_io(1'b0, 8'h04, 32'h0, 32'(w), 1'b0, "ctrl1");
  endtask : cfg
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    reg_io(1'b0, 8'h00, 32'h0, 32'h000, 1'b0, "ctrl0 reset");
    reg_io(1'b1, 8'h04, 32'h3FF, 32'h0, 1'b0, "ctrl1 ro");
    reg_io(1'b0, 8'h04, 32'h0, 32'h030, 1'b0, "ctrl1 reset");
    reg_io(1'b1, 8'h08, 32'h3, 32'h0, 1'b0, "chan wr");
    reg_io(1'b0, 8'h08, 32'h0, 32'h3, 1'b0, "chan rd");
    reg_io(1'b0, 8'h10, 32'h0, 32'h0, 1'b1, "unmapped");
    $display("test regs done");
  endtask : t_regs
  task automatic run_thr(input int n, input logic [9:0] b);
    for (int i = 0; i < n - 1; i++) push(b + 10'(i));
    repeat (3) @(posedge pclk);
    chk(32'(flag), 32'h0, "flag early");
    push(b + 10'(n - 1));
    wflag(1'b1, 8, "flag set");
    for (int i = 0; i < n; i++) begin
      ahp_host_model_inst.host_rd();
      chk(32'(data_out), 32'(b + 10'(i)), "order");
      if (i == 0) chk(32'(flag), 32'h0, "flag drop");
    end
    reg_io(1'b0, 8'h0C, 32'h0, 32'h0, 1'b0, "status");
  endtask : run_thr
  task automatic t_table();
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        if (c == 3 && k == 3) continue;
        cfg(2'(c), 10'h020 | 10'(k << 2));
        run_thr(thr_t[c][k], 10'(c * 64 + k * 16));
      end
    end
    $display("test table done");
  endtask : t_table
  task automatic t_pulse();
    int n;
    cfg(2'h0, 10'h010);
    chk(32'(flag), 32'h1, "idle low pol");
    sclk_run = 1'b1;
    push(10'h155);
    wflag(1'b0, 30, "pulse");
    n = 0;
    while (flag === 1'b0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'h4, "width");
    push(10'h0AA);
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      n += int'(flag === 1'b0);
    end
    chk(32'(n), 32'h0, "no repeat");
    fork
      ahp_host_model_inst.host_rd();
      wflag(1'b0, 30, "rearm");
    join
    chk(32'(data_out), 32'h155, "pulse data");
    ahp_host_model_inst.host_rd();
    sclk_run = 1'b0;
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_comb();
    cfg(2'h0, 10'h060);
    ahp_host_model_inst.comb = 1'b1;
    push(10'h2AA);
    wflag(1'b1, 8, "comb flag");
    ahp_host_model_inst.host_rd();
    chk(32'(data_out), 32'h2AA, "comb read");
    ahp_host_model_inst.host_wr(1'b1, 10'h024);
    reg_io(1'b0, 8'h04, 32'h0, 32'h024, 1'b0, "comb write");
    ahp_host_model_inst.comb = 1'b0;
    $display("test comb done");
  endtask : t_comb
  task automatic end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_table();
    t_pulse();
    t_comb();
    end_sim();
  end
  // watchdog
  initial begin
    #500000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb_top
bind ahp_host_port ahp_host_monitor #(.DW(DW)) ahp_host_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .select_low_n(select_low_n),
  .select_high(select_high), .wr_n(wr_n), .data_out(data_out), .data_oe(data_oe),
  .results_ready_flag(results_ready_flag));
`default_nettype wire
